/* hw/sfp_pin_if.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_pin_if (
  input  wire logic                  clk,             // core clock
  input  wire logic                  sys_rst,         // sync reset
  input  wire logic                  cs_n_pin,        // chip select, low
  input  wire logic                  sclk_pin,        // serial clock
  input  wire logic [3:0]            lane_in,         // lane levels
  output logic      [3:0]            lane_out,        // lane drive data
  output logic      [3:0]            lane_oe,         // lane drive enable
  input  wire sfp_pkg::sfp_mode_type mode,            // lane width
  input  wire logic                  quad_enable_bit, // quad enable
  input  wire logic                  out_phase,       // read output phase
  input  wire logic                  internal_busy,   // program/erase busy
  output logic      [7:0]            rx_data,         // received byte
  output logic                       rx_valid,        // byte available
  input  wire logic                  rx_ready,        // core takes byte
  output logic                       rx_overrun,      // byte lost
  input  wire logic [7:0]            tx_data,         // read byte
  input  wire logic                  tx_valid,        // read byte offered
  output logic                       tx_ready,        // read byte taken
  output logic                       standby,         // standby power
  output logic                       active,          // active power
  output logic                       instr_active,    // instruction open
  output logic                       hold_active,     // transfer paused
  output logic                       write_protect,   // hw protect asserted
  output logic                       deselect_pulse   // cs went high
);
  import sfp_pkg::*;

  logic [SFP_NSYNC-1:0] s1_reg;
  logic [SFP_NSYNC-1:0] s2_reg;
  logic [SFP_NSYNC-1:0] s3_reg;
  logic [SFP_NSYNC-1:0] flt_reg;
  logic [SFP_NSYNC-1:0] pin_vec;
  logic                 cs_f;
  logic                 sclk_f;
  logic [3:0]           lane_f;
  logic                 cs_prev_reg;
  logic                 sclk_prev_reg;
  logic                 cs_fall;
  logic                 cs_rise;
  logic                 sclk_rise;
  logic                 sclk_fall;
  sfp_state_type        state_reg;
  sfp_state_type        state_next;
  logic                 hold_fn;
  sfp_mode_type         eff_mode;
  logic [3:0]           step;
  logic [7:0]           rx_sh_reg;
  logic [7:0]           rx_sh_next;
  logic [3:0]           rx_cnt_reg;
  logic [3:0]           rx_cnt_next;
  logic                 rx_done;
  logic [7:0]           pend_data_reg;
  logic                 pend_reg;
  logic                 push;
  logic                 fifo_ready;
  logic [7:0]           tx_sh_reg;
  logic [3:0]           tx_cnt_reg;
  logic                 tx_shift;
  logic [7:0]           tx_src;

  // pins gathered in synchroniser order
  assign pin_vec = {lane_in, sclk_pin, cs_n_pin};

  // three-stage synchroniser, a level counts once stages two and three agree
  for (genvar i = 0; i < SFP_NSYNC; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        s1_reg[i]  <= SFP_SYNC_RST[i];
        s2_reg[i]  <= SFP_SYNC_RST[i];
        s3_reg[i]  <= SFP_SYNC_RST[i];
        flt_reg[i] <= SFP_SYNC_RST[i];
      end else begin
        s1_reg[i] <= pin_vec[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i]) flt_reg[i] <= s3_reg[i];
      end
    end
  end

  assign cs_f   = flt_reg[SFP_IX_CS];
  assign sclk_f = flt_reg[SFP_IX_SCLK];
  assign lane_f = flt_reg[SFP_IX_LANE +: SFP_LANES];

  // edge history; the clock level is tracked even when deselected so an
  // idle-high clock at selection never looks like an edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_prev_reg   <= SFP_SYNC_RST[SFP_IX_CS];
      sclk_prev_reg <= SFP_SYNC_RST[SFP_IX_SCLK];
    end else begin
      cs_prev_reg   <= cs_f;
      sclk_prev_reg <= sclk_f;
    end
  end

  assign cs_fall   = cs_prev_reg & ~cs_f;
  assign cs_rise   = ~cs_prev_reg & cs_f;
  // clock edges only count while selected and not paused
  assign sclk_rise = (state_reg == SFP_ST_ACTIVE) & ~sclk_prev_reg & sclk_f;
  assign sclk_fall = (state_reg == SFP_ST_ACTIVE) & sclk_prev_reg & ~sclk_f;

  // quad lanes only exist with the quad enable bit set
  assign eff_mode = (mode == SFP_MODE_QUAD && !quad_enable_bit) ?
                    SFP_MODE_SINGLE : mode;
  assign hold_fn  = ~quad_enable_bit & (eff_mode != SFP_MODE_QUAD);

  always_comb begin
    step = 4'h1;
    unique case (eff_mode)
      SFP_MODE_SINGLE: step = 4'h1;
      SFP_MODE_DUAL:   step = 4'h2;
      SFP_MODE_QUAD:   step = 4'h4;
      default:         step = 4'h1;
    endcase
  end

  // selection and hold; leaving reset needs a falling cs edge, and cs already low after reset counts as one
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SFP_ST_DESEL: begin
        if (cs_fall) state_next = SFP_ST_ACTIVE;
      end
      SFP_ST_ACTIVE: begin
        if (cs_f) state_next = SFP_ST_DESEL;
        else if (hold_fn && !lane_f[3] && !sclk_f)
          state_next = SFP_ST_HOLD;
      end
      SFP_ST_HOLD: begin
        if (cs_f) state_next = SFP_ST_DESEL;
        else if ((lane_f[3] || !hold_fn) && !sclk_f)
          state_next = SFP_ST_ACTIVE;
      end
      default: state_next = SFP_ST_DESEL;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) state_reg <= SFP_ST_DESEL;
    else state_reg <= state_next;
  end

  // input shifter, lanes picked by width
  always_comb begin
    rx_sh_next = rx_sh_reg;
    unique case (eff_mode)
      SFP_MODE_SINGLE: rx_sh_next = {rx_sh_reg[6:0], lane_f[0]};
      SFP_MODE_DUAL:   rx_sh_next = {rx_sh_reg[5:0], lane_f[1:0]};
      SFP_MODE_QUAD:   rx_sh_next = {rx_sh_reg[3:0], lane_f};
      default:         rx_sh_next = {rx_sh_reg[6:0], lane_f[0]};
    endcase
  end

  assign rx_cnt_next = rx_cnt_reg + step;
  assign rx_done     = sclk_rise & ~out_phase & (rx_cnt_next == SFP_CNT_FULL);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_sh_reg  <= SFP_BYTE_RST;
      rx_cnt_reg <= SFP_CNT_RST;
    end else if (cs_rise) begin
      rx_sh_reg  <= SFP_BYTE_RST;
      rx_cnt_reg <= SFP_CNT_RST;
    end else if (sclk_rise && !out_phase) begin
      rx_sh_reg  <= rx_sh_next;
      rx_cnt_reg <= rx_done ? SFP_CNT_RST : rx_cnt_next;
    end
  end

  // one-byte holding slot ahead of the buffer; the host cannot be stalled,
  // so a second full byte while the slot is still blocked is an overrun
  assign push = pend_reg & fifo_ready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_reg      <= 1'b0;
      pend_data_reg <= SFP_BYTE_RST;
    end else if (rx_done && (!pend_reg || push)) begin
      pend_reg      <= 1'b1;
      pend_data_reg <= rx_sh_next;
    end else if (push) begin
      pend_reg <= 1'b0;
    end
  end

  // set wins over the clear at deselect
  always_ff @(posedge clk) begin
    if (sys_rst) rx_overrun <= 1'b0;
    else if (rx_done && pend_reg && !push) rx_overrun <= 1'b1;
    else if (cs_rise) rx_overrun <= 1'b0;
  end

  sfp_fifo2 #(
    .WIDTH (SFP_BYTE_W),
    .DEPTH (SFP_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (pend_data_reg),
    .in_valid  (pend_reg),
    .in_ready  (fifo_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // read data moves only on falling clock edges
  assign tx_shift = sclk_fall & out_phase;
  assign tx_ready = tx_shift & (tx_cnt_reg == SFP_CNT_RST) & tx_valid;
  assign tx_src   = (tx_cnt_reg == SFP_CNT_RST) ? tx_data : tx_sh_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_sh_reg  <= SFP_BYTE_RST;
      tx_cnt_reg <= SFP_CNT_RST;
      lane_out   <= SFP_OE_NONE;
    end else if (cs_rise) begin
      tx_cnt_reg <= SFP_CNT_RST;
    end else if (tx_shift && (tx_cnt_reg != SFP_CNT_RST || tx_valid)) begin
      tx_sh_reg  <= tx_src << step;
      tx_cnt_reg <= (tx_cnt_reg == SFP_CNT_RST) ?
                    SFP_CNT_FULL - step : tx_cnt_reg - step;
      unique case (eff_mode)
        SFP_MODE_SINGLE: lane_out <= {2'b00, tx_src[7], 1'b0};
        SFP_MODE_DUAL:   lane_out <= {2'b00, tx_src[7:6]};
        SFP_MODE_QUAD:   lane_out <= tx_src[7:4];
        default:         lane_out <= {2'b00, tx_src[7], 1'b0};
      endcase
    end
  end

  // lanes drive only in an output phase; sampling never meets own drive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lane_oe <= SFP_OE_NONE;
    end else if (state_next != SFP_ST_ACTIVE || !out_phase) begin
      lane_oe <= SFP_OE_NONE;
    end else begin
      unique case (eff_mode)
        SFP_MODE_SINGLE: lane_oe <= SFP_OE_SGL;
        SFP_MODE_DUAL:   lane_oe <= SFP_OE_DUAL;
        SFP_MODE_QUAD:   lane_oe <= SFP_OE_QUAD;
        default:         lane_oe <= SFP_OE_NONE;
      endcase
    end
  end

  // power and status levels
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      standby        <= 1'b1;
      active         <= 1'b0;
      instr_active   <= 1'b0;
      hold_active    <= 1'b0;
      write_protect  <= 1'b0;
      deselect_pulse <= 1'b0;
    end else begin
      standby        <= (state_reg == SFP_ST_DESEL) & ~internal_busy;
      active         <= (state_reg != SFP_ST_DESEL);
      instr_active   <= (state_reg != SFP_ST_DESEL);
      hold_active    <= (state_reg == SFP_ST_HOLD);
      write_protect  <= ~quad_enable_bit & ~lane_f[2];
      deselect_pulse <= cs_rise;
    end
  end

endmodule // sfp_pin_if
`default_nettype wire

/* include/sfp_pkg.sv */
// Overview of operation
// - While chip select is high the block is deselected, ignores every pin but the lane 2 write-protect level, and drives no pin.
// - When deselected the block reports standby, unless an internal program, erase or status write is still busy.
// - A low chip select enables the block, reports active power and flags an instruction in progress.
// - Nothing is decoded after reset until a falling edge of chip select has been seen; the code also counts cs already low after reset as one.
// - Every incoming instruction, address and data bit is captured on a rising serial clock edge.
// - Output data bits change only after a falling serial clock edge.
// - In single-line operation lane 0 carries all incoming bits, one per clock.
// - In dual and quad operation lane 0 is bidirectional, input on rising edges, read data on falling edges.
// - Lane 1 is the read-data output in single-line operation and bidirectional in dual or quad.
// - Lane 2 is a write-protect input in single and dual operation and a data lane in quad.
// - Lane 3 pauses the transfer when low in single or dual operation with the quad enable bit clear, and is a data lane in quad.
// - Both an idle-low and an idle-high serial clock at selection are accepted.
// - With the quad enable bit set, write protect is off and lane 2 is data only.
// - A hold starts while lane 3 is low and ends while lane 3 is high, each only while the clock is low.
package sfp_pkg;

  localparam int SFP_BYTE_W     = 8;
  localparam int SFP_CNT_W      = 4;
  localparam int SFP_LANES      = 4;
  localparam int SFP_FIFO_DEPTH = 2;
  localparam int SFP_NSYNC      = 6;
  // positions in the synchroniser vector
  localparam int SFP_IX_CS      = 0;
  localparam int SFP_IX_SCLK    = 1;
  localparam int SFP_IX_LANE    = 2;
  // cs high, clock low, lanes high (pulled up)
  localparam logic [5:0] SFP_SYNC_RST = 6'h3d;
  localparam logic [3:0] SFP_CNT_RST  = 4'h0;
  localparam logic [7:0] SFP_BYTE_RST = 8'h00;
  localparam logic [3:0] SFP_CNT_FULL = 4'h8;
  localparam logic [3:0] SFP_OE_NONE  = 4'h0;
  localparam logic [3:0] SFP_OE_SGL   = 4'h2;
  localparam logic [3:0] SFP_OE_DUAL  = 4'h3;
  localparam logic [3:0] SFP_OE_QUAD  = 4'hf;

  typedef enum logic [2:0] {
    SFP_MODE_SINGLE = 3'b001,
    SFP_MODE_DUAL   = 3'b010,
    SFP_MODE_QUAD   = 3'b100
  } sfp_mode_type;

  typedef enum logic [2:0] {
    SFP_ST_DESEL  = 3'b001,
    SFP_ST_ACTIVE = 3'b010,
    SFP_ST_HOLD   = 3'b100
  } sfp_state_type;

endpackage

/* hw/sfp_fifo2.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_fifo2 #(
  parameter int WIDTH = sfp_pkg::SFP_BYTE_W,
  parameter int DEPTH = sfp_pkg::SFP_FIFO_DEPTH
) (
  input  wire logic             clk,       // core clock
  input  wire logic             sys_rst,   // sync reset
  input  wire logic [WIDTH-1:0] in_data,   // write data
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // room for a word
  output logic      [WIDTH-1:0] out_data,  // head word
  output logic                  out_valid, // head valid
  input  wire logic             out_ready  // reader takes head
);
  import sfp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  // count is one bit wider than the pointers so full is distinct from empty
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_reg];

  // one write port per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        mem_reg[i] <= '0;
      end else if (push && wr_reg == AW'(i)) begin
        mem_reg[i] <= in_data;
      end
    end
  end

  // pointers wrap naturally, depth is a power of two
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + AW'(1);
      if (pop) rd_reg <= rd_reg + AW'(1);
      if (push && !pop) cnt_reg <= cnt_reg + (AW+1)'(1);
      else if (pop && !push) cnt_reg <= cnt_reg - (AW+1)'(1);
    end
  end

endmodule // sfp_fifo2
`default_nettype wire

/* tb/sfp_pin_if_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_pin_if_props
  import sfp_pkg::*;
(
  input wire logic         clk,             // core clock
  input wire logic         sys_rst,         // sync reset
  input wire logic         cs_n_pin,        // chip select pin
  input wire logic         sclk_pin,        // serial clock pin
  input wire logic [3:0]   lane_in,         // lane levels
  input wire logic [3:0]   lane_out,        // lane drive data
  input wire logic [3:0]   lane_oe,         // lane drive enable
  input wire sfp_mode_type mode,            // lane width
  input wire logic         quad_enable_bit, // quad enable
  input wire logic         out_phase,       // read output phase
  input wire logic         internal_busy,   // internal busy
  input wire logic         rx_valid,        // byte available
  input wire logic         rx_overrun,      // byte lost
  input wire logic         standby,         // standby power
  input wire logic         active,          // active power
  input wire logic         instr_active,    // instruction open
  input wire logic         hold_active,     // paused
  input wire logic         write_protect,   // protect asserted
  input wire logic         deselect_pulse   // cs went high
);
  // one clock domain, reset disables every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // synchroniser latency leaves 8 cycles of slack after a cs rise
  desel_oe_off_a: assert property (cs_n_pin [*8] |-> lane_oe == 4'h0)
    else $error("lanes driven while deselected");
  standby_power_a: assert property (!$past(sys_rst) |->
    standby == (!active && !$past(internal_busy)))
    else $error("standby level wrong");
  select_active_a: assert property ($fell(cs_n_pin) ##1 !cs_n_pin [*7]
    |-> active && instr_active)
    else $error("selection not active");
  desel_pulse_a: assert property ($rose(cs_n_pin) |-> ##[3:8] deselect_pulse)
    else $error("no clear pulse after deselect");
  desel_clear_a: assert property (deselect_pulse |->
    ##[1:3] (!active && !rx_overrun))
    else $error("state not cleared at deselect");
  phase_oe_a: assert property (!out_phase ##1 !out_phase |-> lane_oe == 4'h0)
    else $error("lanes driven outside read phase");
  lane_width_a: assert property (lane_oe != 4'h0 |-> lane_oe ==
    (($past(mode) == SFP_MODE_DUAL) ? SFP_OE_DUAL :
     ($past(mode) == SFP_MODE_QUAD && $past(quad_enable_bit)) ?
     SFP_OE_QUAD : SFP_OE_SGL))
    else $error("lane enable pattern wrong");
  out_change_a: assert property ($changed(lane_out) && $past(active)
    |-> !$past(sclk_pin, 2))
    else $error("output moved without falling clock");
  hold_entry_a: assert property ($rose(hold_active) |->
    !$past(lane_in[3], 3) && !$past(sclk_pin, 3) && !quad_enable_bit)
    else $error("hold entered illegally");
  wp_quad_off_a: assert property ($past(quad_enable_bit) |-> !write_protect)
    else $error("write protect with quad on");
  rx_select_a: assert property ($rose(rx_valid) |-> !$past(cs_n_pin, 8))
    else $error("byte received while deselected");
endmodule // sfp_pin_if_props
`default_nettype wire

/* tb/sfp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
  input  wire logic       clk,   // bench clock
  input  wire logic [3:0] lane,  // resolved lane levels
  output logic            cs_n,  // chip select
  output logic            sclk,  // serial clock
  output logic      [3:0] h_dat, // host lane data
  output logic      [3:0] h_oe   // host lane enable
);
  logic idle_hi; // clock idle level of this selection

  // idle: deselected, clock low, lanes released
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    h_dat = 4'hf;
    h_oe = 4'h0;
    idle_hi = 1'b0;
  end

  // pins move one step after the bench clock edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // clock parks at its idle level before cs falls
  task automatic sel(input logic hi);
    idle_hi = hi;
    sclk = hi;
    cyc(6);
    cs_n = 1'b0;
    cyc(8);
  endtask

  // released lanes 0 and 1 flip so stale data never reads as valid
  task automatic desel();
    sclk = idle_hi;
    cyc(6);
    cs_n = 1'b1;
    h_oe = 4'h0;
    h_dat[1:0] = ~h_dat[1:0];
    cyc(12);
  endtask

  // msb first, data set on the low phase, hold lane kept as it was
  task automatic shift(input logic [7:0] b, input int w, input int nb);
    logic [7:0] s;
    s = b;
    h_oe = (w == 4) ? 4'hf : {h_oe[3], (w == 2) ? 3'h3 : 3'h1};
    repeat (nb / w) begin
      sclk = 1'b0;
      h_dat = (w == 4) ? s[7:4] :
              {h_dat[3], 1'b1, (w == 2) ? s[7:6] : {1'b1, s[7]}};
      s = s << w;
      cyc(6);
      sclk = 1'b1;
      cyc(6);
    end
  endtask

  // lanes released; each bit sampled late in the high phase
  task automatic read(output logic [7:0] b, input int w);
    h_oe = 4'h0;
    h_dat[1:0] = ~h_dat[1:0];
    b = 8'h00;
    repeat (8 / w) begin
      sclk = 1'b0;
      cyc(6);
      sclk = 1'b1;
      cyc(5);
      b = (w == 1) ? {b[6:0], lane[1]} :
          (w == 2) ? {b[5:0], lane[1:0]} : {b[3:0], lane};
      cyc(1);
    end
  endtask
endmodule // sfp_host_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfp_pkg::*;
  logic         clk, sys_rst, cs_n_pin, sclk_pin, quad_enable_bit, out_phase;
  logic         internal_busy, rx_valid, rx_ready, rx_overrun, tx_valid;
  logic         tx_ready, standby, active, instr_active, hold_active;
  logic         write_protect, deselect_pulse;
  logic [3:0]   lane_in, lane_out, lane_oe, h_dat, h_oe;
  logic [7:0]   rx_data, tx_data;
  sfp_mode_type mode;
  int           n_errors, cmp_count, n_taken;

  sfp_pin_if dut (.clk(clk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .lane_in(lane_in), .lane_out(lane_out),
    .lane_oe(lane_oe), .mode(mode), .quad_enable_bit(quad_enable_bit),
    .out_phase(out_phase), .internal_busy(internal_busy),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_overrun(rx_overrun), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .standby(standby), .active(active),
    .instr_active(instr_active), .hold_active(hold_active),
    .write_protect(write_protect), .deselect_pulse(deselect_pulse));
  sfp_host_model host (.clk(clk), .lane(lane_in), .cs_n(cs_n_pin),
    .sclk(sclk_pin), .h_dat(h_dat), .h_oe(h_oe));

  // read bytes taken; sampled mid-cycle where the pulse has settled
  always @(negedge clk) begin
    if (tx_ready) n_taken++;
  end

  // released lanes 2 and 3 rise through their pull-ups
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_in[i] = lane_oe[i] ? lane_out[i] : h_oe[i] ? h_dat[i] : (i > 1) | h_dat[i];
    end
  end

  // 250 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  task automatic pop();
    rx_ready = 1'b1;
    host.cyc(1);
    rx_ready = 1'b0;
    host.cyc(2);
  endtask

  // deselected: clocks and read phase are ignored, busy blocks standby
  task automatic t_busy();
    internal_busy = 1'b1;
    out_phase = 1'b1;
    host.shift(8'h5a, 1, 8);
    chk1(standby, 1'b0);
    chk({4'h0, lane_oe}, 8'h00);
    chk1(rx_valid, 1'b0);
    internal_busy = 1'b0;
    out_phase = 1'b0;
    host.cyc(3);
    chk1(standby, 1'b1);
  endtask

  // one byte in on each lane width, clock idle level alternating
  task automatic t_rx();
    for (int k = 0; k < 3; k++) begin
      mode = sfp_mode_type'(3'h1 << k);
      quad_enable_bit = (k == 2);
      host.sel(k[0]);
      chk1(active, 1'b1);
      chk1(instr_active, 1'b1);
      host.shift(8'h3c ^ 8'(k * 17), 1 << k, 8);
      host.desel();
      chk(rx_data, 8'h3c ^ 8'(k * 17));
      pop();
      chk1(standby, 1'b1);
    end
  endtask

  // command in, then a byte shifted out on falling edges per width
  task automatic t_read();
    logic [7:0] b;
    logic [3:0] oe_t [3] = '{SFP_OE_SGL, SFP_OE_DUAL, SFP_OE_QUAD};
    int t0;
    for (int k = 0; k < 3; k++) begin
      mode = sfp_mode_type'(3'h1 << k);
      quad_enable_bit = (k == 2);
      tx_data = 8'h96 + 8'(k);
      tx_valid = 1'b1;
      host.sel(1'b0);
      host.shift(8'h0b, 1 << k, 8);
      out_phase = 1'b1;
      host.cyc(2);
      chk({4'h0, lane_oe}, {4'h0, oe_t[k]});
      t0 = n_taken;
      host.read(b, 1 << k);
      chk(b, 8'h96 + 8'(k));
      tx_valid = 1'b0;
      out_phase = 1'b0;
      host.cyc(2);
      chk({4'h0, lane_oe}, 8'h00);
      chk(8'(n_taken - t0), 8'h01);
      host.desel();
      chk(rx_data, 8'h0b);
      pop();
    end
  endtask

  // hold waits for clock low, drops edges while held, keeps the byte
  task automatic t_hold();
    mode = SFP_MODE_SINGLE;
    quad_enable_bit = 1'b0;
    host.sel(1'b0);
    host.shift(8'ha0, 1, 4);
    host.h_dat[3] = 1'b0;
    host.h_oe[3] = 1'b1;
    host.cyc(8);
    chk1(hold_active, 1'b0);
    host.sclk = 1'b0;
    host.cyc(8);
    chk1(hold_active, 1'b1);
    chk({4'h0, lane_oe}, 8'h00);
    host.sclk = 1'b1;
    host.cyc(8);
    host.sclk = 1'b0;
    host.h_dat[3] = 1'b1;
    host.cyc(8);
    chk1(hold_active, 1'b0);
    host.shift(8'h50, 1, 4);
    host.desel();
    chk(rx_data, 8'ha5);
    pop();
  endtask

  // write protect follows lane 2 only while quad is off
  task automatic t_wp();
    host.sel(1'b0);
    host.h_dat[2] = 1'b0;
    host.h_oe[2] = 1'b1;
    for (int q = 0; q < 2; q++) begin
      quad_enable_bit = q[0];
      host.cyc(8);
      chk1(write_protect, !q[0]);
    end
    host.desel();
  endtask

  // partial byte dropped; receiver stalls until the buffer overflows
  task automatic t_fill();
    // quad asked without the enable bit must behave as single-line
    mode = SFP_MODE_QUAD;
    quad_enable_bit = 1'b0;
    host.sel(1'b1);
    host.shift(8'hff, 1, 3);
    host.desel();
    chk1(rx_valid, 1'b0);
    host.sel(1'b0);
    for (int i = 1; i < 5; i++) host.shift(8'h11 * 8'(i), 1, 8);
    host.cyc(4);
    chk1(rx_overrun, 1'b1);
    for (int i = 1; i < 4; i++) begin
      chk(rx_data, 8'h11 * 8'(i));
      pop();
    end
    chk1(rx_valid, 1'b0);
    host.desel();
    chk1(rx_overrun, 1'b0);
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // the whole sequence needs about 1500 cycles; 25000 means a hang
  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  // reset for 4 cycles, then the scenarios in turn
  initial begin
    sys_rst = 1'b1;
    mode = SFP_MODE_SINGLE;
    quad_enable_bit = 1'b0;
    out_phase = 1'b0;
    internal_busy = 1'b0;
    rx_ready = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    host.cyc(2);
    chk1(standby, 1'b1);
    chk1(active, 1'b0);
    t_busy();
    t_rx();
    t_read();
    t_hold();
    t_wp();
    t_fill();
    summarize();
  end
endmodule // tb_top

bind sfp_pin_if sfp_pin_if_props u_props (.clk(clk), .sys_rst(sys_rst),
  .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .lane_in(lane_in),
  .lane_out(lane_out), .lane_oe(lane_oe), .mode(mode),
  .quad_enable_bit(quad_enable_bit), .out_phase(out_phase),
  .internal_busy(internal_busy), .rx_valid(rx_valid),
  .rx_overrun(rx_overrun), .standby(standby), .active(active),
  .instr_active(instr_active), .hold_active(hold_active),
  .write_protect(write_protect), .deselect_pulse(deselect_pulse));
`default_nettype wire
